// ==== fpio_pkg.sv ====
// Shared constants and types of the four pin general purpose port.
// Assumes a 32-bit APB register bus with byte addresses and one aligned word per register.
package fpio_pkg;

   // Pin counts: four pins read back, the three low ones can also drive.
   localparam int NPIN = 4;           // Pins whose level can be read.
   localparam int NIO  = 3;           // Pins that have a driver, latch and analog select.

   // Register byte offsets.
   localparam logic [7:0] OFF_LEVEL  = 8'h00; // Pin level register, writes go to the latch.
   localparam logic [7:0] OFF_DIR    = 8'h04; // Pin direction bits, 1 means input.
   localparam logic [7:0] OFF_LATCH  = 8'h08; // Output latch.
   localparam logic [7:0] OFF_ANALOG = 8'h0c; // Analog select bits.
   localparam logic [7:0] OFF_PULLUP = 8'h10; // Pull-up enable bits.
   localparam logic [7:0] OFF_OPTION = 8'h14; // Option register with the global pull-up disable.

   // Field positions.
   localparam int POS_PU_DIS   = 0;   // Global pull-up disable bit in the option register.
   localparam int POS_DIR_RSVD = 3;   // Unimplemented direction bit of the input-only pin.

   // Reset values.
   localparam logic [2:0] RST_DIR      = 3'h7; // All pins start as inputs.
   localparam logic [2:0] RST_LATCH    = 3'h0; // Latch starts low.
   localparam logic [2:0] RST_ANALOG   = 3'h7; // The three low pins start in analog mode.
   localparam logic [3:0] RST_PULLUP   = 4'hf; // Every per-pin pull-up enable starts set.
   localparam logic       RST_PU_DIS   = 1'b1; // Pull-ups globally disabled after reset.
   localparam logic       DIR_RSVD_VAL = 1'b1; // Read value of the unimplemented direction bit.

   // Controls presented to the pad ring, one field per pad function.
   typedef struct packed {
      logic [NIO-1:0]  oe;     // Output driver enable, high while the pin is driven.
      logic [NIO-1:0]  dout;   // Level driven while oe is high.
      logic [NPIN-1:0] pull;   // Weak pull-up switched on.
      logic [NPIN-1:0] din_en; // Digital input buffer enabled.
   } fpio_pad_type;

endpackage

// ==== fpio_pin_mux.sv ====
// Output priority selector for one pin shared between several peripherals.
// Assumes source 0 has the highest priority and the port latch is handled by the caller.
module fpio_pin_mux #(
   parameter int NSRC = 2          // Number of peripherals that may claim the pin.
) (
   input  wire logic [NSRC-1:0] src_oe,  // Output enable of each peripheral.
   input  wire logic [NSRC-1:0] src_do,  // Output value of each peripheral.
   output      logic            claimed, // Some peripheral owns the pin.
   output      logic            value    // Value of the owning peripheral.
);

   // Walk from the lowest priority upward so that the lowest index is written last and wins.
   always_comb begin
      claimed = 1'b0;
      value   = 1'b0;
      for (int s = NSRC - 1; s >= 0; s--) begin
         if (src_oe[s]) begin
            claimed = 1'b1;
            value   = src_do[s];
         end
      end
   end

endmodule

// ==== fpio_port.sv ====
// Four pin general purpose I/O port with an APB register slave and pad controls.
// Assumes pins arrive synchronous enough to be resynchronised here and that the pad ring
// resolves the wire from pad_o; peripherals present their enables and values on pclk.
//
// How it works
// - Direction bit one switches the driver off unless a peripheral claims the pin.
// - Direction bit zero drives latch onto pin.
// - Level register writes land in the latch.
// - Latch reads return stored latch values.
// - Level reads return the real pin levels.
// - Port writes merge sampled pins into latch.
// - Analog select disables the digital input buffer.
// - Analog pins read as zero in level reads, not in port write sampling.
// - Analog select never blocks digital output.
// - Reset puts the three low pins into analog mode.
// - Each pin has its own pull-up enable.
// - Output pins lose their pull-up automatically.
// - Reset disables all pull-ups globally.
// - Peripheral ownership stops port output only.
// - Highest priority peripheral owns the pin.
// - Fourth pin is input only.
//
// Implementation choices: register access over APB and the register offsets.
module fpio_port #(
   parameter int NSRC = 2                        // Peripherals that may claim each output pin.
) (
   input  wire logic                  pclk,        // Bus and port clock.
   input  wire logic                  presetn,     // Asynchronous reset, active low.
   input  wire logic                  psel,        // APB select.
   input  wire logic                  penable,     // APB access phase.
   input  wire logic                  pwrite,      // APB direction, high for write.
   input  wire logic [7:0]            paddr,       // APB byte address.
   input  wire logic [31:0]           pwdata,      // APB write data.
   input  wire logic [3:0]            pstrb,       // APB write byte strobes.
   output      logic [31:0]           prdata,      // APB read data.
   output      logic                  pready,      // APB ready.
   output      logic                  pslverr,     // APB error for an unmapped address.
   input  wire logic [3:0]            pin_i,       // Levels seen on the four pins.
   input  wire logic [NSRC-1:0][2:0]  periph_oe_i, // Peripheral output enables per pin.
   input  wire logic [NSRC-1:0][2:0]  periph_do_i, // Peripheral output values per pin.
   output      fpio_pkg::fpio_pad_type pad_o       // Registered pad controls.
);

   // Synchroniser stages; only the second stage feeds the rest of the block.
   logic [3:0]             sync1_r, sync1_nxt;     // First stage.
   logic [3:0]             sync2_r, sync2_nxt;     // Second stage.

   // Software visible state. The input-only pin has no direction, latch or analog bit.
   logic [2:0]             dir_r, dir_nxt;         // Pin direction bits.
   logic [2:0]             lat_r, lat_nxt;         // Output latch.
   logic [2:0]             ana_r, ana_nxt;         // Analog select bits.
   logic [3:0]             pu_r, pu_nxt;           // Pull-up enable bits.
   logic                   pu_dis_r, pu_dis_nxt;   // Global pull-up disable.

   // Bus answer state.
   logic [31:0]            prdata_r, prdata_nxt;   // Read data captured in the setup cycle.
   logic                   pready_r, pready_nxt;   // Ready for the access phase.
   logic                   pslverr_r, pslverr_nxt; // Error for the access phase.

   // Pad controls.
   fpio_pkg::fpio_pad_type pad_r, pad_nxt;         // Registered pad outputs.

   // Combinational helpers.
   logic [3:0]             pin_val;                // Pin levels as software reads them.
   logic [2:0]             rmw_val;                // Value that a port write stores.
   logic [31:0]            rd_val;                 // Read value of the addressed register.
   logic                   hit;                    // Address is mapped.
   logic                   setup;                  // APB setup cycle.
   logic                   wr_done;                // APB write completes at this edge.
   logic [2:0]             periph_any;             // A peripheral owns the pin.
   logic [2:0]             periph_val;             // Value of the owning peripheral.

   // Resynchronise the pins; the first stage is read by the second stage alone.
   always_comb begin
      sync1_nxt = pin_i;
      sync2_nxt = sync1_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
      end
   end

   // Analog pins have no digital input, so their level reads as zero.
   assign pin_val = sync2_r & ~{1'b0, ana_r};

   // Bus phase decode.
   assign setup   = psel & ~penable;
   assign wr_done = psel & penable & pready_r & pwrite;

   // Read multiplexer and address decode.
   always_comb begin
      rd_val = 32'h0;
      hit    = 1'b1;
      case (paddr)
         fpio_pkg::OFF_LEVEL: begin
            rd_val[3:0] = pin_val;
         end
         fpio_pkg::OFF_DIR: begin
            rd_val[2:0] = dir_r;
            rd_val[fpio_pkg::POS_DIR_RSVD] = fpio_pkg::DIR_RSVD_VAL;
         end
         fpio_pkg::OFF_LATCH: begin
            rd_val[2:0] = lat_r;
         end
         fpio_pkg::OFF_ANALOG: begin
            rd_val[2:0] = ana_r;
         end
         fpio_pkg::OFF_PULLUP: begin
            rd_val[3:0] = pu_r;
         end
         fpio_pkg::OFF_OPTION: begin
            rd_val[fpio_pkg::POS_PU_DIS] = pu_dis_r;
         end
         default: begin
            hit = 1'b0; // Unmapped words read zero and answer with an error.
         end
      endcase
   end

   // The answer is prepared during the setup cycle so that every bus output is a flop.
   // This costs no wait state: ready is already high in the first access cycle.
   always_comb begin
      pready_nxt  = setup;
      pslverr_nxt = setup & ~hit;
      prdata_nxt  = prdata_r;
      if (setup) begin
         prdata_nxt = pwrite ? 32'h0 : rd_val;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end else begin
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   // A port write is read-modify-write over the whole port: the pins are sampled and the
   // strobed byte replaces them. A write without the low strobe therefore copies the pin
   // levels into the latch, which is the known hazard of this style of port.
   assign rmw_val = pstrb[0] ? pwdata[2:0] : sync2_r[2:0];

   // Register writes; the other registers only change under the low byte strobe.
   always_comb begin
      dir_nxt    = dir_r;
      lat_nxt    = lat_r;
      ana_nxt    = ana_r;
      pu_nxt     = pu_r;
      pu_dis_nxt = pu_dis_r;
      if (wr_done && !pslverr_r) begin
         case (paddr)
            fpio_pkg::OFF_LEVEL, fpio_pkg::OFF_LATCH: begin
               lat_nxt = rmw_val;
            end
            fpio_pkg::OFF_DIR: begin
               if (pstrb[0]) begin
                  dir_nxt = pwdata[2:0];
               end
            end
            fpio_pkg::OFF_ANALOG: begin
               if (pstrb[0]) begin
                  ana_nxt = pwdata[2:0];
               end
            end
            fpio_pkg::OFF_PULLUP: begin
               if (pstrb[0]) begin
                  pu_nxt = pwdata[3:0];
               end
            end
            fpio_pkg::OFF_OPTION: begin
               if (pstrb[0]) begin
                  pu_dis_nxt = pwdata[fpio_pkg::POS_PU_DIS];
               end
            end
            default: begin
               lat_nxt = lat_r; // Unmapped writes change nothing.
            end
         endcase
      end
   end

   // Software registers. The three low pins come up as analog inputs with pull-ups globally off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r    <= fpio_pkg::RST_DIR;
         lat_r    <= fpio_pkg::RST_LATCH;
         ana_r    <= fpio_pkg::RST_ANALOG;
         pu_r     <= fpio_pkg::RST_PULLUP;
         pu_dis_r <= fpio_pkg::RST_PU_DIS;
      end else begin
         dir_r    <= dir_nxt;
         lat_r    <= lat_nxt;
         ana_r    <= ana_nxt;
         pu_r     <= pu_nxt;
         pu_dis_r <= pu_dis_nxt;
      end
   end

   // One priority selector per output-capable pin.
   for (genvar i = 0; i < fpio_pkg::NIO; i++) begin : g_pin
      logic [NSRC-1:0] oe_col; // Enables of all peripherals on this pin.
      logic [NSRC-1:0] do_col; // Values of all peripherals on this pin.

      always_comb begin
         for (int s = 0; s < NSRC; s++) begin
            oe_col[s] = periph_oe_i[s][i];
            do_col[s] = periph_do_i[s][i];
         end
      end

      fpio_pin_mux #(
         .NSRC    (NSRC)
      ) u_mux (
         .src_oe  (oe_col),
         .src_do  (do_col),
         .claimed (periph_any[i]),
         .value   (periph_val[i])
      );
   end

   // Pad controls. Analog select only feeds din_en here on purpose: it only touches the input side.
   always_comb begin
      pad_nxt        = pad_r;
      pad_nxt.oe     = periph_any | ~dir_r;
      pad_nxt.dout   = (periph_any & periph_val) | (~periph_any & lat_r);
      pad_nxt.pull   = pu_r & ~{1'b0, pad_nxt.oe} & {4{~pu_dis_r}};
      pad_nxt.din_en = ~{1'b0, ana_r};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_r.oe     <= ~fpio_pkg::RST_DIR;
         pad_r.dout   <= fpio_pkg::RST_LATCH;
         pad_r.pull   <= 4'h0;
         pad_r.din_en <= ~{1'b0, fpio_pkg::RST_ANALOG};
      end else begin
         pad_r <= pad_nxt;
      end
   end

   // Outputs straight from flops.
   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign pad_o   = pad_r;

   // A pin set as input and unclaimed is never driven one cycle later.
   a_input_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
      ((pad_r.oe & $past(dir_r) & ~$past(periph_any)) == 3'h0))
      else $error("input pin is being driven");

   // An unclaimed output pin drives its latch value, whatever its analog select says.
   a_output_drives_latch: assert property (@(posedge pclk) disable iff (!presetn)
      (((~pad_r.oe | (pad_r.dout ^ $past(lat_r))) & ~$past(dir_r) & ~$past(periph_any)) == 3'h0))
      else $error("output pin does not drive its latch");

   // A strobed write to the level register reaches the latch at the completing edge.
   a_level_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && paddr == fpio_pkg::OFF_LEVEL && pstrb[0]) |=> (lat_r == $past(pwdata[2:0])))
      else $error("level register write missed the latch");

   // A latch read returns the latch contents.
   a_latch_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && !pwrite && paddr == fpio_pkg::OFF_LATCH) |->
      (prdata == {29'h0, lat_r}))
      else $error("latch read returned wrong data");

   // A level read returns the synchronised pins with analog pins forced low.
   a_level_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == fpio_pkg::OFF_LEVEL) |=>
      (prdata == {28'h0, $past(sync2_r) & ~{1'b0, $past(ana_r)}}))
      else $error("level read returned wrong data");

   // A write without the low strobe stores the sampled pin levels.
   a_rmw_merge: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && paddr == fpio_pkg::OFF_LATCH && !pstrb[0]) |=> (lat_r == $past(sync2_r[2:0])))
      else $error("read-modify-write lost the pin levels");

   // Digital input buffers follow the analog select bits.
   a_analog_buffer: assert property (@(posedge pclk) disable iff (!presetn)
      pad_r.din_en == ~{1'b0, $past(ana_r)})
      else $error("input buffer does not follow analog select");

   // Output pins never keep a pull-up, and a global disable keeps them all off.
   a_pull_off_out: assert property (@(posedge pclk) disable iff (!presetn)
      ((pad_r.pull[2:0] & pad_r.oe) == 3'h0) && (!$past(pu_dis_r) || pad_r.pull == 4'h0))
      else $error("pull-up active on an output or while disabled");

   // The top-priority claim on pin 0 wins over the latch.
   a_periph_wins: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(presetn) && $past(periph_oe_i[0][0])) |-> (pad_r.oe[0] && pad_r.dout[0] == $past(periph_do_i[0][0])))
      else $error("highest priority peripheral lost the pin");

endmodule

// ==== fpio_board.sv ====
// Board model for the four port pins: external drivers, pull-ups, floating nodes.
// Assumes the pad controls of the port and the bus clock for the float pattern.
module fpio_board (
   input  wire logic                   pclk,   // Clock of the float pattern.
   input  wire fpio_pkg::fpio_pad_type pad,    // Pad controls of the port.
   input  wire logic [3:0]             ext_en, // Board driver switched on.
   input  wire logic [3:0]             ext_v,  // Board driver level.
   output      logic [3:0]             pin     // Resolved pin levels.
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] flt = 4'h5;                 // Undriven nodes toggle, so a stale level never passes.
   logic [3:0] oe4;                        // Port driver enables, pin 3 has none.
   logic [3:0] do4;                        // Port driver levels.
   assign oe4 = {1'b0, pad.oe};
   assign do4 = {1'b0, pad.dout};
   // An undriven node without pull-up changes every cycle.
   always @(posedge pclk) begin
      flt <= ~flt;
   end
   // The port driver wins, then the board driver, then the pull-up.
   assign pin = (oe4 & do4) | (~oe4 & ((ext_en & ext_v) | (~ext_en & (pad.pull | flt & ~pad.pull))));
endmodule

// ==== testbench.sv ====
// Self-checking bench of the four pin port: APB master, pin stimulus, pad and bus checks.
// Assumes the port answers each access in one cycle and the board model resolves the pins.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic                   pclk = 1'b0, presetn = 1'b0;      // Clock and reset.
   logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls.
   logic [7:0]             paddr = 8'h00;                   // APB address.
   logic [31:0]            pwdata = 32'h0, prdata;          // APB data.
   logic [3:0]             pstrb = 4'h0, pin, ext_en = 4'h0, ext_v = 4'h0; // Strobes and pins.
   logic                   pready, pslverr;                 // APB answer.
   logic [1:0][2:0]        p_oe = '0, p_do = '0;            // Peripheral claims.
   fpio_pkg::fpio_pad_type pad;                             // Pad controls.
   logic [2:0]             dir_s = 3'h7, lat_s = 3'h0, an_s = 3'h7; // Expected register state.
   logic [3:0]             pu_s = 4'hf;                     // Expected pull-up enables.
   logic                   dis_s = 1'b1;                    // Expected global pull-up disable.
   logic [33:0]            notes[$];                        // Read flag, error and data.
   logic [33:0]            note;                            // Note being compared.
   int                     mismatches = 0, checked = 0;     // Counters.
   always #5 pclk = ~pclk;
   fpio_port #(.NSRC(2)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_i(pin), .periph_oe_i(p_oe), .periph_do_i(p_do),
      .pad_o(pad));
   fpio_board i_board (.pclk(pclk), .pad(pad), .ext_en(ext_en), .ext_v(ext_v), .pin(pin));
   // Prints the counts and the verdict, then ends the run.
   task stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Shared tally of one comparison.
   task tally(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus result: error flag and read data.
   task cmp_bus(input logic [32:0] got, input logic [32:0] exp);
      tally(got, exp);
   endtask
   // Expected pad controls from the register copies and the claims.
   function automatic fpio_pkg::fpio_pad_type exp_pad();
      fpio_pkg::fpio_pad_type e;
      for (int i = 0; i < 3; i++) begin
         e.oe[i] = ~dir_s[i] | p_oe[0][i] | p_oe[1][i];
         e.dout[i] = p_oe[0][i] ? p_do[0][i] : (p_oe[1][i] ? p_do[1][i] : lat_s[i]);
         e.pull[i] = pu_s[i] & ~e.oe[i] & ~dis_s;
      end
      e.pull[3] = pu_s[3] & ~dis_s;
      e.din_en = {1'b1, ~an_s};
      return e;
   endfunction
   // Expected level read; only used when every pin is driven or pulled.
   function automatic logic [31:0] exp_lvl();
      fpio_pkg::fpio_pad_type e;
      logic [3:0]             o;
      e = exp_pad();
      o = {1'b0, e.oe};
      return {28'h0, ((o & {1'b0, e.dout}) | (~o & ((ext_en & ext_v) | (~ext_en & e.pull)))) & {1'b1, ~an_s}};
   endfunction
   // Pad result; the driven level only counts where the driver is on.
   task cmp_pad();
      fpio_pkg::fpio_pad_type e;
      e = exp_pad();
      tally({19'h0, pad.oe, pad.dout & e.oe, pad.pull, pad.din_en}, {19'h0, e.oe, e.dout & e.oe, e.pull, e.din_en});
   endtask
   // One APB transfer; the request is held until pready is seen and then left for the next call.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [32:0] e);
      notes.push_back({~wr, e});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf, 33'h0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'hf, {1'b0, e});
   endtask
   // Releases the bus and lets n edges pass.
   task idle(input int n);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask
   // Takes the oldest note at each completed transfer; writes only check the error flag.
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
         note = notes.pop_front();
         cmp_bus({pslverr, (note[33] ? prdata : 32'h0)}, note[32:0]);
      end
   end
   // A hang counts as a mismatch.
   initial begin
      #30000;
      mismatches++;
      stop_test();
   end
   // Main sequence.
   initial begin
      void'($urandom(32'haa64));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      cmp_pad();
      rd(fpio_pkg::OFF_DIR, 32'hf);
      rd(fpio_pkg::OFF_LATCH, 32'h0);
      rd(fpio_pkg::OFF_ANALOG, 32'h7);
      rd(fpio_pkg::OFF_PULLUP, 32'hf);
      rd(fpio_pkg::OFF_OPTION, 32'h1);
      apb(1'b0, 8'h18, 32'h0, 4'hf, {1'b1, 32'h0});
      wr(fpio_pkg::OFF_ANALOG, 32'h0);
      an_s = 3'h0;
      wr(fpio_pkg::OFF_OPTION, 32'h0);
      dis_s = 1'b0;
      idle(4);
      cmp_pad();
      rd(fpio_pkg::OFF_LEVEL, exp_lvl());
      for (int k = 0; k < 3; k++) begin
         ext_en <= 4'hf;
         ext_v <= 4'($urandom());
         idle(4);
         rd(fpio_pkg::OFF_LEVEL, exp_lvl());
      end
      apb(1'b1, fpio_pkg::OFF_LATCH, 32'($urandom()), 4'h0, 33'h0);
      lat_s = ext_v[2:0];
      rd(fpio_pkg::OFF_LATCH, {29'h0, lat_s});
      ext_en <= 4'h8;
      wr(fpio_pkg::OFF_LEVEL, 32'($urandom()) | 32'h1);
      lat_s = pwdata[2:0];
      idle(4);
      rd(fpio_pkg::OFF_LATCH, {29'h0, lat_s});
      rd(fpio_pkg::OFF_LEVEL, exp_lvl());
      wr(fpio_pkg::OFF_DIR, 32'h0);
      dir_s = 3'h0;
      rd(fpio_pkg::OFF_DIR, 32'h8);
      idle(4);
      cmp_pad();
      rd(fpio_pkg::OFF_LEVEL, exp_lvl());
      wr(fpio_pkg::OFF_ANALOG, 32'h7);
      an_s = 3'h7;
      idle(4);
      cmp_pad();
      rd(fpio_pkg::OFF_LEVEL, exp_lvl());
      wr(fpio_pkg::OFF_DIR, 32'h7);
      dir_s = 3'h7;
      wr(fpio_pkg::OFF_ANALOG, 32'h0);
      an_s = 3'h0;
      wr(fpio_pkg::OFF_PULLUP, 32'h5);
      pu_s = 4'h5;
      rd(fpio_pkg::OFF_PULLUP, 32'h5);
      for (int k = 0; k < 6; k++) begin
         p_oe <= 6'($urandom());
         p_do <= 6'($urandom());
         ext_en <= 4'hf;
         ext_v <= 4'($urandom());
         idle(4);
         cmp_pad();
         rd(fpio_pkg::OFF_LEVEL, exp_lvl());
      end
      wr(fpio_pkg::OFF_OPTION, 32'h1);
      dis_s = 1'b1;
      idle(3);
      cmp_pad();
      // A second reset in mid-run, with peripheral claims still present, must restore the analog, latch and direction registers.
      presetn <= 1'b0;
      idle(2);
      presetn <= 1'b1;
      dir_s = 3'h7;
      lat_s = 3'h0;
      an_s = 3'h7;
      pu_s = 4'hf;
      idle(2);
      cmp_pad();
      rd(fpio_pkg::OFF_ANALOG, 32'h7);
      rd(fpio_pkg::OFF_LATCH, 32'h0);
      rd(fpio_pkg::OFF_DIR, 32'hf);
      stop_test();
   end
endmodule
